//--- motor_drive_regs.vh
// Purpose: Register offsets, field positions, reset values and timing counts for the motor drive.
// Assumes: Core clock of 25 MHz on ref_clk_in.
// Notes:   Definitions only.
`ifndef MOTOR_DRIVE_REGS_VH
`define MOTOR_DRIVE_REGS_VH

// ==========================================================================
// Register offsets
`define DIR_SPEED_CFG_OFS    8'h0E
`define BRAKE_DT_CFG_OFS     8'h12
`define LEAD_ANGLE_CFG_OFS   8'h15
`define CUR_GATE_CFG_OFS     8'h17
`define PWM_CFG_OFS          8'h16
`define CFG_RESET            8'h00

// ==========================================================================
// Field positions
`define DIR_INVERT_BIT       6
`define BRAKE_POLARITY_BIT   4
`define LEAD_CODE_MSB        7
`define LEAD_CODE_LSB        4
`define BAND_WIDTH_MSB       1
`define BAND_WIDTH_LSB       0
`define CUR_LEVEL_BIT        6
`define PWM_FREQ_MSB         4
`define PWM_FREQ_LSB         2

// ==========================================================================
// Timing
`define CLK_HZ               25000000
`define INT_CLK_DIV          2
`define HALF_BAND_NARROW_HZ  50
`define HALF_BAND_WIDE_HZ    100
`define FIXED_LEAD_MAX       4'h8
`define FORCE_STEP_US        10000
`define FORCE_STEP_CYC       (`FORCE_STEP_US * (`CLK_HZ / 1000000))
`define SINE_SWITCH_ZC       8
`define PERIOD_MAX           22'h3FFFFF

`endif

//--- motor_drive_angle_dir_brake_pwm.v
// Purpose: Lead angle, speed bands, commutation mode, direction, brake and PWM period logic.
// Assumes: Configuration writes come from the serial slave on the same clock.
// Notes:   Sine waveform synthesis and gate drive lie outside this block.
`timescale 1ns/1ps
`default_nettype none
`include "motor_drive_regs.vh"

module motor_drive_angle_dir_brake_pwm #(
    parameter integer FORCE_STEP_CYC = `FORCE_STEP_CYC,
    parameter integer SWITCH_ZC      = `SINE_SWITCH_ZC
) (
    input  wire        ref_clk_in,
    input  wire        rst_in,
    input  wire [7:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_wr_in,
    output reg  [7:0]  reg_rdata_out,
    input  wire        run_in,
    input  wire        direction_pin_in,
    input  wire        brake_pin_in,
    input  wire        bemf_zero_cross_in,
    output reg         current_limit_level_out,
    output reg         amp_gain_x20_out,
    output reg  [3:0]  lead_angle_out,
    output reg  [2:0]  speed_band_out,
    output reg         forced_mode_out,
    output reg         sine_mode_out,
    output reg  [2:0]  commutation_step_out,
    output reg         outputs_off_out,
    output reg         reverse_out,
    output reg         short_brake_out,
    output reg  [1:0]  pwm_div_sel_out,
    output reg  [8:0]  pwm_count_out,
    output reg         pwm_period_start_out
);

    // ======================================================================
    // Configuration registers
    reg [7:0] dir_speed_cfg_reg;
    reg [7:0] brake_dt_cfg_reg;
    reg [7:0] lead_angle_cfg_reg;
    reg [7:0] cur_gate_cfg_reg;
    reg [7:0] pwm_cfg_reg;

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            dir_speed_cfg_reg  <= `CFG_RESET;
            brake_dt_cfg_reg   <= `CFG_RESET;
            lead_angle_cfg_reg <= `CFG_RESET;
            cur_gate_cfg_reg   <= `CFG_RESET;
            pwm_cfg_reg        <= `CFG_RESET;
            reg_rdata_out      <= 8'h00;
        end else begin
            if (reg_wr_in) begin
                case (reg_addr_in)
                    `DIR_SPEED_CFG_OFS:  dir_speed_cfg_reg  <= reg_wdata_in;
                    `BRAKE_DT_CFG_OFS:   brake_dt_cfg_reg   <= reg_wdata_in;
                    `LEAD_ANGLE_CFG_OFS: lead_angle_cfg_reg <= reg_wdata_in;
                    `CUR_GATE_CFG_OFS:   cur_gate_cfg_reg   <= reg_wdata_in;
                    `PWM_CFG_OFS:        pwm_cfg_reg        <= reg_wdata_in;
                    default:             ;
                endcase
            end
            case (reg_addr_in)
                `DIR_SPEED_CFG_OFS:  reg_rdata_out <= dir_speed_cfg_reg;
                `BRAKE_DT_CFG_OFS:   reg_rdata_out <= brake_dt_cfg_reg;
                `LEAD_ANGLE_CFG_OFS: reg_rdata_out <= lead_angle_cfg_reg;
                `CUR_GATE_CFG_OFS:   reg_rdata_out <= cur_gate_cfg_reg;
                `PWM_CFG_OFS:        reg_rdata_out <= pwm_cfg_reg;
                default:             reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // ======================================================================
    // Pin synchronisers
    reg [1:0] dir_sync_reg;
    reg [1:0] brake_sync_reg;
    reg [1:0] zc_sync_reg;
    reg       zc_last_reg;
    wire      zc_pulse = zc_sync_reg[1] & ~zc_last_reg;

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            dir_sync_reg   <= 2'b00;
            brake_sync_reg <= 2'b00;
            zc_sync_reg    <= 2'b00;
            zc_last_reg    <= 1'b0;
        end else begin
            dir_sync_reg   <= {dir_sync_reg[0], direction_pin_in};
            brake_sync_reg <= {brake_sync_reg[0], brake_pin_in};
            zc_sync_reg    <= {zc_sync_reg[0], bemf_zero_cross_in};
            zc_last_reg    <= zc_sync_reg[1];
        end
    end

    // ======================================================================
    // Electrical period measurement between rising U zero crossings
    reg  [21:0] period_cnt_reg;
    reg  [21:0] period_reg;
    wire        stalled = (period_cnt_reg == `PERIOD_MAX);

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            period_cnt_reg <= 22'h000000;
            period_reg     <= `PERIOD_MAX;
        end else if (zc_pulse) begin
            period_cnt_reg <= 22'h000000;
            period_reg     <= period_cnt_reg;
        end else if (!stalled) begin
            period_cnt_reg <= period_cnt_reg + 22'h000001;
        end else begin
            period_reg     <= `PERIOD_MAX;
        end
    end

    // ======================================================================
    // Speed bands: index 0 for lead angle (selectable width), 1 for PWM (wide)
    wire [2:0] band_w [0:1];
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_band
            reg  [2:0]  band_reg;
            wire        wide   = (g == 1) || (lead_angle_cfg_reg[`BAND_WIDTH_MSB:`BAND_WIDTH_LSB]
                                              != 2'b00);
            wire [32:0] half   = wide ? 33'd`HALF_BAND_WIDE_HZ : 33'd`HALF_BAND_NARROW_HZ;
            wire [32:0] up_thr = {29'd0, band_reg + 3'd1, 1'b0} * half;
            wire [32:0] dn_thr = ({29'd0, band_reg, 1'b0} - 33'd1) * half;
            wire [32:0] p_ext  = {11'd0, period_reg};
            always @(posedge ref_clk_in) begin
                if (rst_in || stalled) begin
                    band_reg <= 3'd0;
                end else if (zc_pulse) begin
                    if (band_reg != 3'd5 && p_ext * up_thr < 33'd`CLK_HZ) begin
                        band_reg <= band_reg + 3'd1;
                    end else if (band_reg != 3'd0 && p_ext * dn_thr >= 33'd`CLK_HZ) begin
                        band_reg <= band_reg - 3'd1;
                    end
                end
            end
            assign band_w[g] = band_reg;
        end
    endgenerate

    // ======================================================================
    // Lead angle in steps of 3.75 degrees
    function [3:0] banded_lead;
        input [3:0] code;
        input [2:0] band;
        reg   [23:0] row;
        begin
            case (code)
                4'h9:    row = 24'h654442;
                4'hA:    row = 24'h654422;
                4'hB:    row = 24'h543210;
                4'hC:    row = 24'h654321;
                4'hD:    row = 24'h765432;
                4'hE:    row = 24'h876543;
                default: row = 24'h887531;
            endcase
            banded_lead = row[band * 4 +: 4];
        end
    endfunction

    function [1:0] banded_pwm;
        input [1:0] code;
        input [2:0] band;
        reg   [11:0] row;
        begin
            case (code)
                2'd0:    row = 12'hEA5;
                2'd1:    row = 12'hAA4;
                2'd2:    row = 12'hA50;
                default: row = 12'hFA4;
            endcase
            banded_pwm = row[band * 2 +: 2];
        end
    endfunction

    wire [3:0] lead_code = lead_angle_cfg_reg[`LEAD_CODE_MSB:`LEAD_CODE_LSB];
    wire [2:0] pwm_code  = pwm_cfg_reg[`PWM_FREQ_MSB:`PWM_FREQ_LSB];
    wire [1:0] div_next  = pwm_code[2] ? banded_pwm(pwm_code[1:0], band_w[1])
                                       : pwm_code[1:0];

    // ======================================================================
    // Internal clock tick and PWM period counter
    reg        int_tick_reg;
    wire [8:0] period_last = 9'h1FF >> pwm_div_sel_out;

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            int_tick_reg         <= 1'b0;
            pwm_count_out        <= 9'h000;
            pwm_div_sel_out      <= 2'b00;
            pwm_period_start_out <= 1'b0;
            reverse_out          <= 1'b0;
            short_brake_out      <= 1'b0;
        end else begin
            int_tick_reg         <= ~int_tick_reg;
            pwm_period_start_out <= 1'b0;
            if (int_tick_reg) begin
                if (pwm_count_out >= period_last) begin
                    pwm_count_out        <= 9'h000;
                    pwm_period_start_out <= 1'b1;
                    pwm_div_sel_out      <= div_next;
                    reverse_out          <= dir_sync_reg[1] ^
                                            dir_speed_cfg_reg[`DIR_INVERT_BIT];
                    short_brake_out      <= brake_sync_reg[1] ^
                                            brake_dt_cfg_reg[`BRAKE_POLARITY_BIT];
                end else begin
                    pwm_count_out <= pwm_count_out + 9'h001;
                end
            end
        end
    end

    // ======================================================================
    // Commutation sequence
    localparam [2:0] ST_IDLE   = 3'b001;
    localparam [2:0] ST_FORCED = 3'b010;
    localparam [2:0] ST_SINE   = 3'b100;

    reg [2:0]  state_reg;
    reg [31:0] step_cnt_reg;
    reg [3:0]  zc_count_reg;
    wire [21:0] blank_start = period_reg - (period_reg >> 3);

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_reg            <= ST_IDLE;
            step_cnt_reg         <= 32'd0;
            zc_count_reg         <= 4'd0;
            commutation_step_out <= 3'd0;
            outputs_off_out      <= 1'b1;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    outputs_off_out <= 1'b1;
                    zc_count_reg    <= 4'd0;
                    step_cnt_reg    <= 32'd0;
                    if (run_in && !short_brake_out) begin
                        state_reg <= ST_FORCED;
                    end
                end
                ST_FORCED: begin
                    outputs_off_out <= 1'b0;
                    if (step_cnt_reg >= FORCE_STEP_CYC - 1) begin
                        step_cnt_reg         <= 32'd0;
                        commutation_step_out <= (commutation_step_out == 3'd5) ? 3'd0 :
                                                commutation_step_out + 3'd1;
                    end else begin
                        step_cnt_reg <= step_cnt_reg + 32'd1;
                    end
                    if (zc_pulse) begin
                        zc_count_reg <= zc_count_reg + 4'd1;
                    end
                    if (!run_in || short_brake_out) begin
                        state_reg <= ST_IDLE;
                    end else if (zc_count_reg >= SWITCH_ZC) begin
                        state_reg <= ST_SINE;
                    end
                end
                ST_SINE: begin
                    // Blanking opens in the last eighth of the previous period.
                    outputs_off_out <= !zc_pulse && period_cnt_reg >= blank_start;
                    if (!run_in || short_brake_out || stalled) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Registered status outputs
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            current_limit_level_out <= 1'b0;
            amp_gain_x20_out        <= 1'b0;
            lead_angle_out          <= 4'h0;
            speed_band_out          <= 3'd0;
            forced_mode_out         <= 1'b0;
            sine_mode_out           <= 1'b0;
        end else begin
            current_limit_level_out <= cur_gate_cfg_reg[`CUR_LEVEL_BIT];
            amp_gain_x20_out        <= cur_gate_cfg_reg[`CUR_LEVEL_BIT];
            lead_angle_out          <= (lead_code <= `FIXED_LEAD_MAX) ? lead_code :
                                       banded_lead(lead_code, band_w[0]);
            speed_band_out          <= band_w[0];
            forced_mode_out         <= (state_reg == ST_FORCED);
            sine_mode_out           <= (state_reg == ST_SINE);
        end
    end

endmodule // motor_drive_angle_dir_brake_pwm
`default_nettype wire

//--- motor_drive_monitor.sv
// Purpose: Port-level checks for the motor drive control block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to the design top.
`timescale 1ns/1ps
`default_nettype none
module motor_drive_monitor #(
    parameter integer FORCE_STEP_CYC = 20,
    parameter integer SWITCH_ZC      = 2
) (
    input wire       ref_clk_in,
    input wire       rst_in,
    input wire       current_limit_level_out,
    input wire       amp_gain_x20_out,
    input wire [3:0] lead_angle_out,
    input wire [2:0] speed_band_out,
    input wire       forced_mode_out,
    input wire       sine_mode_out,
    input wire       reverse_out,
    input wire       short_brake_out,
    input wire [1:0] pwm_div_sel_out,
    input wire [8:0] pwm_count_out,
    input wire       pwm_period_start_out
);
// ==========================================================================
// Properties
default clocking cb @(posedge ref_clk_in);
endclocking
default disable iff (rst_in);
// Pin-driven state may only move at the wrap, which restarts the carrier.
sequence s_wrap;
    pwm_period_start_out && pwm_count_out == 9'h000;
endsequence
property p_gain; amp_gain_x20_out == current_limit_level_out; endproperty
property p_lead; lead_angle_out <= 4'h8; endproperty
property p_band; speed_band_out <= 3'h5; endproperty
property p_dir; $changed(reverse_out) |-> s_wrap; endproperty
property p_brake; $changed(short_brake_out) |-> s_wrap; endproperty
property p_div; $changed(pwm_div_sel_out) |-> s_wrap; endproperty
property p_pulse; pwm_period_start_out |=> !pwm_period_start_out [*8]; endproperty
property p_cnt; pwm_count_out <= (9'h1FF >> pwm_div_sel_out); endproperty
property p_tick; $changed(pwm_count_out) |=> $stable(pwm_count_out); endproperty
property p_modes; !(forced_mode_out && sine_mode_out); endproperty
property p_sine; $rose(sine_mode_out) |-> $past(forced_mode_out); endproperty
a_gain: assert property (p_gain) else $error("gain not tied to level");
a_lead: assert property (p_lead) else $error("lead angle above 30");
a_band: assert property (p_band) else $error("band above 5");
a_dir: assert property (p_dir) else $error("direction moved off wrap");
a_brake: assert property (p_brake) else $error("brake moved off wrap");
a_div: assert property (p_div) else $error("divider moved off wrap");
a_pulse: assert property (p_pulse) else $error("wrap pulse too long");
a_cnt: assert property (p_cnt) else $error("carrier count too high");
a_tick: assert property (p_tick) else $error("carrier not halved");
a_modes: assert property (p_modes) else $error("two modes at once");
a_sine: assert property (p_sine) else $error("sine entered not from forced");
endmodule // motor_drive_monitor
bind motor_drive_angle_dir_brake_pwm motor_drive_monitor #(
    .FORCE_STEP_CYC(FORCE_STEP_CYC),
    .SWITCH_ZC(SWITCH_ZC)
) mon (.ref_clk_in, .rst_in, .current_limit_level_out, .amp_gain_x20_out,
    .lead_angle_out, .speed_band_out, .forced_mode_out, .sine_mode_out, .reverse_out,
    .short_brake_out, .pwm_div_sel_out, .pwm_count_out, .pwm_period_start_out);
`default_nettype wire

//--- motor_bemf_model.sv
// Purpose: Spinning motor seen through the U-phase back-EMF comparator.
// Assumes: Steady speed once the drive is commutating.
// Notes:   A stopped motor leaves the comparator low.
`timescale 1ns/1ps
`default_nettype none
module motor_bemf_model #(
    parameter integer HALF_CYC = 200
) (
    input  wire logic ref_clk_in,
    input  wire logic spinning_in,
    output var  logic bemf_zero_cross_out
);
    integer cnt = 0;
    // Rising comparator edge once per electrical turn.
    always @(posedge ref_clk_in) begin
        if (spinning_in !== 1'b1) begin
            cnt <= 0;
            bemf_zero_cross_out <= 1'b0;
        end else if (cnt == HALF_CYC - 1) begin
            cnt <= 0;
            bemf_zero_cross_out <= ~bemf_zero_cross_out;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // motor_bemf_model
`default_nettype wire

//--- motor_drive_angle_dir_brake_pwm_tb.sv
// Purpose: Register-driven tests of the motor drive control block.
// Assumes: Short forced-step and switch counts for simulation.
// Notes:   Inputs change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module motor_drive_angle_dir_brake_pwm_tb;
    logic       ref_clk_in, rst_in, reg_wr_in, run_in, direction_pin_in, brake_pin_in;
    logic       bemf_zero_cross_in, current_limit_level_out, amp_gain_x20_out;
    logic       forced_mode_out, sine_mode_out, outputs_off_out, reverse_out;
    logic       short_brake_out, pwm_period_start_out;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic [3:0] lead_angle_out;
    logic [2:0] speed_band_out, commutation_step_out, s0;
    logic [1:0] pwm_div_sel_out;
    logic [8:0] pwm_count_out;
    int         mismatches = 0, cmp_count = 0, k, n;
    byte        lead_exp[16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 2, 2, 0, 1, 2, 3, 1};
    byte        div_exp[8] = '{0, 1, 2, 3, 1, 0, 0, 0};
    motor_drive_angle_dir_brake_pwm #(.FORCE_STEP_CYC(20), .SWITCH_ZC(2)) DUT (.*);
    motor_bemf_model #(.HALF_CYC(200)) motor (.ref_clk_in,
        .spinning_in(forced_mode_out | sine_mode_out), .bemf_zero_cross_out(bemf_zero_cross_in));
// ==========================================================================
// Tasks
    task automatic chk(input [15:0] seen, input [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input [7:0] a, input [7:0] d);
        @(negedge ref_clk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge ref_clk_in);
        reg_wr_in = 1'b0;
    endtask
    task automatic rd(input [7:0] a, input [7:0] exp);
        @(negedge ref_clk_in);
        reg_addr_in = a;
        @(negedge ref_clk_in);
        chk(reg_rdata_out, exp, "rdata");
    endtask
    // Waits for a carrier wrap, bounded by the longest period.
    task automatic wait_wrap(output int cyc);
        for (cyc = 1; cyc < 1100; cyc++) begin
            @(negedge ref_clk_in);
            if (pwm_period_start_out === 1'b1) break;
        end
    endtask
    task automatic stop_test;
        if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
// ==========================================================================
// Stimulus
    initial begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        #2000000;
        mismatches++;
        stop_test();
    end
    initial begin
        {rst_in, reg_addr_in, reg_wdata_in, reg_wr_in} = {1'b1, 17'h0};
        {run_in, direction_pin_in, brake_pin_in} = 3'h0;
        repeat (2) @(negedge ref_clk_in);
        rst_in = 1'b0;
        chk(outputs_off_out, 1, "idle off");
        rd(8'h0E, 8'h00);
        rd(8'h16, 8'h00);
        wr(8'h01, 8'hFF);
        rd(8'h01, 8'h00);
        for (k = 0; k < 2; k++) begin
            wr(8'h17, 8'(k << 6));
            rd(8'h17, 8'(k << 6));
            chk(current_limit_level_out, k, "limit level");
            chk(amp_gain_x20_out, k, "gain x20");
        end
        for (k = 0; k < 16; k++) begin
            wr(8'h15, 8'(k << 4));
            rd(8'h15, 8'(k << 4));
            chk(lead_angle_out, lead_exp[k], "lead angle");
        end
        for (k = 0; k < 4; k++) begin
            wr(8'h0E, k[1] ? 8'h40 : 8'h00);
            wr(8'h12, k[0] ? 8'h10 : 8'h00);
            direction_pin_in = k[0];
            brake_pin_in = k[1];
            wait_wrap(n);
            wait_wrap(n);
            chk(reverse_out, k[0] ^ k[1], "reverse");
            chk(short_brake_out, k[0] ^ k[1], "brake");
        end
        for (k = 0; k < 8; k++) begin
            wr(8'h16, 8'(k << 2));
            wait_wrap(n);
            chk(pwm_div_sel_out, div_exp[k], "divider");
            wait_wrap(n);
            chk(n, 2 * (512 >> div_exp[k]), "period");
        end
        run_in = 1'b1;
        repeat (10) @(negedge ref_clk_in);
        chk(forced_mode_out, 1, "forced");
        chk(outputs_off_out, 0, "driving");
        s0 = commutation_step_out;
        repeat (20) @(negedge ref_clk_in);
        chk(commutation_step_out, (s0 == 3'h5) ? 3'h0 : s0 + 3'h1, "step");
        for (n = 0; n < 4000 && sine_mode_out !== 1'b1; n++) @(negedge ref_clk_in);
        chk(sine_mode_out, 1, "sine");
        for (n = 0; n < 2000 && outputs_off_out !== 1'b1; n++) @(negedge ref_clk_in);
        chk(outputs_off_out, 1, "detect gap");
        // The model spins far above the top band, so both band counters climb to five.
        repeat (2500) @(negedge ref_clk_in);
        chk(speed_band_out, 5, "speed band");
        chk(lead_angle_out, 8, "banded lead");
        wait_wrap(n);
        chk(pwm_div_sel_out, 3, "banded divider");
        run_in = 1'b0;
        repeat (5) @(negedge ref_clk_in);
        chk(sine_mode_out, 0, "stopped");
        stop_test();
    end
endmodule // motor_drive_angle_dir_brake_pwm_tb
`default_nettype wire
